// >>> hdl/watchdog_interval_timer.sv
// watchdog and interval timer with keyed register writes
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer
  import wdt_pkg::*;
(
  // clock and external reset pin
  input  wire logic      clk,
  input  wire logic      arst_n,
  // cpu bus
  input  wire bus_req_s  busReq,
  output logic [7:0]     readData,
  // standby control
  input  wire logic      standbyRequest,
  input  wire logic      standbyWakeNmi,
  output logic           standbyGranted,
  // chip control and interrupt
  output chip_ctl_s      chipCtl,
  output logic           interval_interrupt
);
  // reset release synchroniser
  logic rstSync1_reg;
  logic rstN;

  // registers
  logic [7:0] tick_counter_reg;
  logic       interval_wrap_flag_reg;
  logic       watchdog_or_interval_select_reg;
  logic       timer_run_enable_reg;
  logic [2:0] tick_divider_select_reg;
  logic       watchdog_wrap_flag_reg;
  logic       chip_reset_enable_reg;
  logic       chip_reset_select_reg;
  logic       flagSeenSet_reg;
  logic       inStandby_reg;
  logic       waking_reg;
  logic [9:0] resetCount_reg;
  logic [7:0] readData_reg;

  // decoded strobes
  logic tick;
  logic countTick;
  logic overflow;
  logic wdOverflow;
  logic itOverflow;
  logic sharedWrite;
  logic writeCount;
  logic writeCtrl;
  logic resetWrite;
  logic wrapClear;
  logic enableWrite;
  logic tcsRead;
  logic rcsRead;
  logic intervalClear;
  logic wakeRelease;
  logic [7:0] tcsValue;
  logic [7:0] rcsValue;

  // release of the asynchronous reset through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_reg <= 1'b0;
      rstN         <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN         <= rstSync1_reg;
    end
  end

  // prescaler keeps running during standby wake so it times settling
  tick_prescaler u_prescaler (
    .clk       (clk),
    .rstN      (rstN),
    .run       (timer_run_enable_reg || waking_reg),
    .divSelect (tick_divider_select_reg),
    .tick      (tick)
  );

  // bus decode; only word writes reach the keyed registers
  assign sharedWrite = busReq.write && busReq.word
                       && (busReq.addr == TIMER_CTL_STAT_ADDR);
  assign writeCount  = sharedWrite && (busReq.wdata[15:8] == KEY_COUNT);
  assign writeCtrl   = sharedWrite && (busReq.wdata[15:8] == KEY_CTRL);
  assign resetWrite  = busReq.write && busReq.word && (busReq.addr == RESET_WR_ADDR);
  assign wrapClear   = resetWrite && (busReq.wdata[15:8] == KEY_CTRL)
                       && (busReq.wdata[7:0] == FLAG_CLEAR_DATA);
  assign enableWrite = resetWrite && (busReq.wdata[15:8] == KEY_COUNT);
  assign tcsRead     = busReq.read && !busReq.word && (busReq.addr == TIMER_CTL_STAT_ADDR);
  assign rcsRead     = busReq.read && !busReq.word && (busReq.addr == RESET_CTL_STAT_ADDR);

  // overflow events
  assign countTick  = tick && (timer_run_enable_reg || waking_reg) && !writeCount;
  assign overflow   = countTick && (tick_counter_reg == COUNT_TOP);
  assign wdOverflow = overflow && timer_run_enable_reg
                      && watchdog_or_interval_select_reg;
  assign itOverflow = overflow && timer_run_enable_reg
                      && !watchdog_or_interval_select_reg;

  // the counter
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tick_counter_reg <= COUNT_ZERO;
    end else if (writeCount) begin
      tick_counter_reg <= busReq.wdata[7:0];
    end else if (wdOverflow && !chip_reset_enable_reg) begin
      tick_counter_reg <= COUNT_ZERO;
    end else if (!timer_run_enable_reg && !waking_reg) begin
      tick_counter_reg <= COUNT_ZERO;
    end else if (countTick) begin
      tick_counter_reg <= tick_counter_reg + 8'h01;
    end
  end

  // interval flag clear needs a prior read that saw it set
  assign intervalClear = writeCtrl && flagSeenSet_reg && !busReq.wdata[TCS_WRAP_BIT];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flagSeenSet_reg <= 1'b0;
    end else if (tcsRead && interval_wrap_flag_reg) begin
      flagSeenSet_reg <= 1'b1;
    end else if (writeCtrl) begin
      flagSeenSet_reg <= 1'b0;
    end
  end

  // interval flag: set wins over clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      interval_wrap_flag_reg <= 1'b0;
    end else if (itOverflow) begin
      interval_wrap_flag_reg <= 1'b1;
    end else if (intervalClear) begin
      interval_wrap_flag_reg <= 1'b0;
    end else if (wdOverflow && !chip_reset_enable_reg) begin
      interval_wrap_flag_reg <= 1'b0;
    end
  end

  // mode and run bits; divider select keeps its value through standby
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      watchdog_or_interval_select_reg <= 1'b0;
      timer_run_enable_reg            <= 1'b0;
      tick_divider_select_reg         <= 3'h0;
    end else if (wdOverflow && !chip_reset_enable_reg) begin
      watchdog_or_interval_select_reg <= 1'b0;
      timer_run_enable_reg            <= 1'b0;
      tick_divider_select_reg         <= 3'h0;
    end else if (standbyGranted) begin
      watchdog_or_interval_select_reg <= 1'b0;
      timer_run_enable_reg            <= 1'b0;
    end else if (writeCtrl) begin
      watchdog_or_interval_select_reg <= busReq.wdata[TCS_MODE_BIT];
      timer_run_enable_reg            <= busReq.wdata[TCS_RUN_BIT];
      tick_divider_select_reg         <= busReq.wdata[2:0];
    end
  end

  // watchdog flag: set wins over the keyed clear; pin reset clears it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      watchdog_wrap_flag_reg <= 1'b0;
    end else if (wdOverflow) begin
      watchdog_wrap_flag_reg <= 1'b1;
    end else if (wrapClear || standbyGranted) begin
      watchdog_wrap_flag_reg <= 1'b0;
    end
  end

  // reset enable and select; untouched by the internal reset itself
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      chip_reset_enable_reg <= 1'b0;
      chip_reset_select_reg <= 1'b0;
    end else if (standbyGranted) begin
      chip_reset_enable_reg <= 1'b0;
      chip_reset_select_reg <= 1'b0;
    end else if (enableWrite) begin
      chip_reset_enable_reg <= busReq.wdata[RCS_ENABLE_BIT];
      chip_reset_select_reg <= busReq.wdata[RCS_SELECT_BIT];
    end
  end

  // chip reset pulse counter; this block only requests the reset, so
  // pin and port registers elsewhere are never cleared by it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      resetCount_reg <= '0;
    end else if (wdOverflow && chip_reset_enable_reg) begin
      resetCount_reg <= CHIP_RESET_LEN;
    end else if (resetCount_reg != '0) begin
      resetCount_reg <= resetCount_reg - 10'h001;
    end
  end

  // one assignment drives the whole struct so it has a single writer
  assign chipCtl = {(resetCount_reg != '0),
                    chip_reset_select_reg,
                    wakeRelease};

  // standby entry refused while the timer runs
  assign standbyGranted = standbyRequest && !timer_run_enable_reg && !inStandby_reg;

  // standby and wake sequencing
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inStandby_reg <= 1'b0;
      waking_reg    <= 1'b0;
    end else if (standbyGranted) begin
      inStandby_reg <= 1'b1;
    end else if (inStandby_reg && !waking_reg && standbyWakeNmi) begin
      waking_reg    <= 1'b1;
    end else if (waking_reg && overflow) begin
      inStandby_reg <= 1'b0;
      waking_reg    <= 1'b0;
    end
  end

  assign wakeRelease = waking_reg && overflow;

  // interrupt request as a one-cycle pulse with the flag
  assign interval_interrupt = itOverflow;

  // read mux, registered
  assign tcsValue = {interval_wrap_flag_reg, watchdog_or_interval_select_reg,
                     timer_run_enable_reg, TCS_RESERVED_VAL, tick_divider_select_reg};
  assign rcsValue = {watchdog_wrap_flag_reg, chip_reset_enable_reg, chip_reset_select_reg,
                     RCS_RESERVED_VAL};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      readData_reg <= 8'h00;
    end else if (busReq.read && !busReq.word) begin
      unique case (busReq.addr)
        TIMER_CTL_STAT_ADDR: readData_reg <= tcsValue;
        TICK_COUNTER_ADDR:   readData_reg <= tick_counter_reg;
        RESET_CTL_STAT_ADDR: readData_reg <= rcsValue;
        default:             readData_reg <= 8'h00;
      endcase
    end
  end

  assign readData = readData_reg;

  // checks
  property p_byte_no_reset_write;
    @(posedge clk) disable iff (!rstN)
      (busReq.write && !busReq.word && !wdOverflow && !standbyGranted)
      |=> $stable(chip_reset_enable_reg);
  endproperty
  a_byte_no_reset_write: assert property (p_byte_no_reset_write)
    else $error("byte write changed reset enable");

  property p_wrap_clear;
    @(posedge clk) disable iff (!rstN)
      (wrapClear && !wdOverflow && !standbyGranted)
      |=> !watchdog_wrap_flag_reg && $stable(chip_reset_enable_reg);
  endproperty
  a_wrap_clear: assert property (p_wrap_clear)
    else $error("watchdog flag not cleared by keyed write");

  property p_enable_copy;
    @(posedge clk) disable iff (!rstN)
      (enableWrite && !standbyGranted && !wdOverflow) |=>
        chip_reset_enable_reg == $past(busReq.wdata[6]) && $stable(watchdog_wrap_flag_reg);
  endproperty
  a_enable_copy: assert property (p_enable_copy)
    else $error("reset enable not copied");

  property p_reset_len;
    @(posedge clk) disable iff (!rstN)
      (wdOverflow && chip_reset_enable_reg) |=> chipCtl.chipReset [*8];
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("chip reset too short");

  property p_reset_ends;
    @(posedge clk) disable iff (!rstN)
      (resetCount_reg == 10'h001) |=> !chipCtl.chipReset;
  endproperty
  a_reset_ends: assert property (p_reset_ends)
    else $error("chip reset overran");

  property p_flag_irq;
    @(posedge clk) disable iff (!rstN)
      interval_interrupt |=> interval_wrap_flag_reg;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("interval flag missing after interrupt");

  property p_standby_refused;
    @(posedge clk) disable iff (!rstN)
      timer_run_enable_reg |-> !standbyGranted;
  endproperty
  a_standby_refused: assert property (p_standby_refused)
    else $error("standby granted while running");

  property p_wd_flag;
    @(posedge clk) disable iff (!rstN)
      wdOverflow |=> watchdog_wrap_flag_reg;
  endproperty
  a_wd_flag: assert property (p_wd_flag)
    else $error("watchdog flag not set");

  property p_write_wins;
    @(posedge clk) disable iff (!rstN)
      writeCount |=> tick_counter_reg == $past(busReq.wdata[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost");

  property p_held_zero;
    @(posedge clk) disable iff (!rstN)
      (!timer_run_enable_reg && !waking_reg && !writeCount) |=> tick_counter_reg == COUNT_ZERO;
  endproperty
  a_held_zero: assert property (p_held_zero)
    else $error("stopped counter not zero");

  c_interval: cover property (@(posedge clk) disable iff (!rstN) interval_interrupt);
  c_chip_reset: cover property (@(posedge clk) disable iff (!rstN) $rose(chipCtl.chipReset));
  c_wake: cover property (@(posedge clk) disable iff (!rstN) chipCtl.standbyRelease);
endmodule
`default_nettype wire

// >>> hdl/wdt_pkg.sv
// package: watchdog interval timer register map, fields, keys and timing
package wdt_pkg;
  // register byte addresses
  localparam logic [31:0] TIMER_CTL_STAT_ADDR = 32'hffff8610;
  localparam logic [31:0] TICK_COUNTER_ADDR   = 32'hffff8611;
  localparam logic [31:0] RESET_WR_ADDR       = 32'hffff8612;
  localparam logic [31:0] RESET_CTL_STAT_ADDR = 32'hffff8613;
  // write keys in the upper byte of a word write; flag clear data in the lower byte
  localparam logic [7:0]  KEY_COUNT           = 8'h5a;
  localparam logic [7:0]  KEY_CTRL            = 8'ha5;
  localparam logic [7:0]  FLAG_CLEAR_DATA     = 8'h00;
  // timer_ctl_stat fields
  localparam int          TCS_WRAP_BIT        = 7;
  localparam int          TCS_MODE_BIT        = 6;
  localparam int          TCS_RUN_BIT         = 5;
  localparam logic [1:0]  TCS_RESERVED_VAL    = 2'h3;
  // reset_ctl_stat fields
  localparam int          RCS_WRAP_BIT        = 7;
  localparam int          RCS_ENABLE_BIT      = 6;
  localparam int          RCS_SELECT_BIT      = 5;
  localparam logic [4:0]  RCS_RESERVED_VAL    = 5'h1f;
  // counter values
  localparam logic [7:0]  COUNT_ZERO          = 8'h00;
  localparam logic [7:0]  COUNT_TOP           = 8'hff;
  // chip reset pulse length in system clocks
  localparam int          CHIP_RESET_CYCLES   = 512;
  localparam logic [9:0]  CHIP_RESET_LEN      = 10'(CHIP_RESET_CYCLES);
  // prescaler
  localparam int          PRESCALE_WIDTH      = 13;

  // one bus access
  typedef struct packed {
    logic        write;   // write strobe (final write state)
    logic        read;    // read strobe
    logic        word;    // 1 = 16-bit, 0 = byte
    logic [31:0] addr;
    logic [15:0] wdata;
  } bus_req_s;

  // outputs toward the chip reset and clock controller
  typedef struct packed {
    logic chipReset;      // internal chip reset request
    logic resetSelect;    // reset type chosen with it
    logic standbyRelease; // clocks may be restored
  } chip_ctl_s;
endpackage

// >>> hdl/tick_prescaler.sv
// tick prescaler: run-gated divider and per-code tick pulse
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstN,
  // control
  input  wire logic       run,
  input  wire logic [2:0] divSelect,
  // tick out
  output logic            tick
);
  logic [PRESCALE_WIDTH-1:0] div_reg;
  logic [PRESCALE_WIDTH-1:0] mask;

  // divider held at zero while stopped so the first period is whole
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      div_reg <= '0;
    end else if (!run) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // mask of low bits; all ones marks the end of one period
  always_comb begin
    unique case (divSelect)
      3'h0:    mask = 13'h0001; // /2
      3'h1:    mask = 13'h003f; // /64
      3'h2:    mask = 13'h007f; // /128
      3'h3:    mask = 13'h00ff; // /256
      3'h4:    mask = 13'h01ff; // /512
      3'h5:    mask = 13'h03ff; // /1024
      3'h6:    mask = 13'h0fff; // /4096
      3'h7:    mask = 13'h1fff; // /8192
      default: mask = 13'h1fff;
    endcase
  end

  assign tick = run && ((div_reg & mask) == mask);
endmodule
`default_nettype wire

// >>> verification/watchdog_interval_timer_tb_top.sv
// testbench: keyed register access, timer modes, watchdog reset and standby wake
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_tb_top
  import wdt_pkg::*;
;
  // divider per select code, kept apart from the design's own tables
  localparam int DIV [8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};

  logic      clk;
  logic      arst_n;
  bus_req_s  busReq;
  logic [7:0] readData;
  logic      standbyRequest;
  logic      standbyWakeNmi;
  logic      standbyGranted;
  chip_ctl_s chipCtl;
  logic      interval_interrupt;
  int        nErrors;
  int        nTests;
  int        rstCycles = 0;
  int        cnt;
  int        i;

  watchdog_interval_timer DUT (
    .clk               (clk),
    .arst_n            (arst_n),
    .busReq            (busReq),
    .readData          (readData),
    .standbyRequest    (standbyRequest),
    .standbyWakeNmi    (standbyWakeNmi),
    .standbyGranted    (standbyGranted),
    .chipCtl           (chipCtl),
    .interval_interrupt(interval_interrupt)
  );

  // 200 mhz system clock
  always #2.5 clk = ~clk;

  // total length of internal chip reset requests seen; sampled mid-cycle
  always @(negedge clk) begin
    if (chipCtl.chipReset === 1'b1) begin
      rstCycles <= rstCycles + 1;
    end
  end

  task automatic close_out();
    if (nErrors == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts are bench values, so a range is enough
  task automatic chkn(input int got, input int lo, input int hi);
    nTests++;
    if (got < lo || got > hi) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic word, input logic [31:0] addr, input logic [15:0] data);
    step();
    busReq.write = 1'b1;
    busReq.word  = word;
    busReq.addr  = addr;
    busReq.wdata = data;
    step();
    busReq.write = 1'b0;
  endtask

  task automatic rd(input logic [31:0] addr, input logic [7:0] exp);
    step();
    busReq.read = 1'b1;
    busReq.word = 1'b0;
    busReq.addr = addr;
    step();
    busReq.read = 1'b0;
    chk8(readData, exp);
  endtask

  // sel 0 interrupt, 1 chip reset, 2 standby release; bounded wait
  task automatic waitSig(input int sel, input int limit, output int n);
    logic hit;
    n   = 0;
    hit = 1'b0;
    while (!hit && n < limit) begin
      step();
      n++;
      hit = (sel == 0) ? interval_interrupt :
            (sel == 1) ? chipCtl.chipReset : chipCtl.standbyRelease;
    end
    chk1(hit, 1'b1);
  endtask

  // watchdog against a hang
  initial begin
    #300000;
    nErrors++;
    close_out();
  end

  initial begin
    clk            = 1'b0;
    arst_n         = 1'b0;
    busReq         = '0;
    standbyRequest = 1'b0;
    standbyWakeNmi = 1'b0;
    nErrors        = 0;
    nTests         = 0;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (3) step();
    // reset values through byte reads
    rd(TIMER_CTL_STAT_ADDR, 8'h18);
    rd(TICK_COUNTER_ADDR, 8'h00);
    rd(RESET_CTL_STAT_ADDR, 8'h1f);
    // byte writes and wrong keys are ignored
    wr(1'b0, RESET_WR_ADDR, {KEY_COUNT, 8'h60});
    wr(1'b1, RESET_WR_ADDR, 16'h3360);
    wr(1'b0, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h20});
    rd(RESET_CTL_STAT_ADDR, 8'h1f);
    rd(TIMER_CTL_STAT_ADDR, 8'h18);
    // enable and select copied, select presented outward
    wr(1'b1, RESET_WR_ADDR, {KEY_COUNT, 8'h60});
    rd(RESET_CTL_STAT_ADDR, 8'h7f);
    chk1(chipCtl.resetSelect, 1'b1);
    // a count written to a stopped counter is cleared on the next clock
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_COUNT, 8'h42});
    rd(TICK_COUNTER_ADDR, 8'h00);
    // shared write address, key picks the target
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h27});
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_COUNT, 8'h42});
    rd(TICK_COUNTER_ADDR, 8'h42);
    rd(TIMER_CTL_STAT_ADDR, 8'h3f);
    // rate per code 1 to 7, read mid-tick so a one-cycle phase slip is harmless
    for (i = 1; i < 8; i++) begin
      wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 5'h00, 3'(i)});
      wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 5'h04, 3'(i)});
      repeat (2 * DIV[i] + DIV[i] / 2) step();
      rd(TICK_COUNTER_ADDR, 8'h02);
    end
    // interval mode at the fastest rate
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h00});
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h20});
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_COUNT, 8'hf0});
    waitSig(0, 100, cnt);
    waitSig(0, 600, cnt);
    chkn(cnt, 512, 512);
    rd(TIMER_CTL_STAT_ADDR, 8'hb8);
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h20});
    rd(TIMER_CTL_STAT_ADDR, 8'h38);
    // watchdog overflow without chip reset
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h00});
    wr(1'b1, RESET_WR_ADDR, {KEY_COUNT, 8'h20});
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h60});
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_COUNT, 8'hf8});
    repeat (40) step();
    rd(RESET_CTL_STAT_ADDR, 8'hbf);
    rd(TIMER_CTL_STAT_ADDR, 8'h18);
    rd(TICK_COUNTER_ADDR, 8'h00);
    chkn(rstCycles, 0, 0);
    wr(1'b1, RESET_WR_ADDR, {KEY_COUNT, 8'h40});
    rd(RESET_CTL_STAT_ADDR, 8'hdf);
    wr(1'b1, RESET_WR_ADDR, {KEY_CTRL, FLAG_CLEAR_DATA});
    rd(RESET_CTL_STAT_ADDR, 8'h5f);
    // watchdog overflow with chip reset; stop early to avoid a retrigger
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h60});
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_COUNT, 8'hf8});
    waitSig(1, 100, cnt);
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h00});
    repeat (600) step();
    chkn(rstCycles, 512, 512);
    rd(RESET_CTL_STAT_ADDR, 8'hdf);
    // pin reset with the timer stopped clears the watchdog flag
    step();
    arst_n = 1'b0;
    repeat (2) step();
    arst_n = 1'b1;
    repeat (3) step();
    rd(RESET_CTL_STAT_ADDR, 8'h1f);
    rd(TIMER_CTL_STAT_ADDR, 8'h18);
    // standby refused while running, then taken and woken
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h20});
    step();
    standbyRequest = 1'b1;
    #1;
    chk1(standbyGranted, 1'b0);
    step();
    standbyRequest = 1'b0;
    // fastest rate kept: settling is taken as shorter than one wrap
    wr(1'b1, TIMER_CTL_STAT_ADDR, {KEY_CTRL, 8'h00});
    step();
    standbyRequest = 1'b1;
    #1;
    chk1(standbyGranted, 1'b1);
    step();
    standbyRequest = 1'b0;
    standbyWakeNmi = 1'b1;
    step();
    standbyWakeNmi = 1'b0;
    waitSig(2, 700, cnt);
    chkn(cnt, 500, 520);
    close_out();
  end
endmodule
`default_nettype wire
